// File: hw/dsss_top.sv
// Drive start/stop sequencer with an AHB-Lite register slave.
//
// What this block does
// R1 - Start mode 0 direct, 1 DC brake first, 2 speed tracking first.
// R2 - Direct start begins at the start frequency, 0 to 50.00 Hz.
// R3 - Hold start frequency for hold time up to 50.0 s, then ramp; no hold time after a pre-start brake or speed tracking.
// R4 - Target below start frequency puts the drive in standby, no output.
// R5 - Start frequency is not clamped to the lower frequency limit.
// R6 - Brake-before-start at its current, accelerate after its full time.
// R7 - Zero pre-start brake time skips the brake phase entirely.
// R8 - Pre-start brake current is 0 to 100.0 % of rated current.
// R9 - Ramp shape 0 changes frequency linearly in both directions.
// R10 - Ramp shape 1 follows an S curve using section times.
// R11 - S curve built from range, ramp times and section times, 0.1 s reset.
// R12 - Stop mode 0 ramps down and stops output at stop speed.
// R13 - Stop mode 1 cuts output at once and lets the load coast.
// R14 - Ramped stop arms post-stop brake at threshold frequency, reset 0 Hz.
// R15 - Output blocked for demagnetisation wait before post-stop brake.
// R16 - Post-stop brake at its current for its time.
// R17 - Post-stop ranges: wait 30 s, current 100 %, brake time 50 s.
// R18 - Mode and brake currents latched at phase start, ramp times and thresholds read live; intervals timed by clock counters.
// R19 - Stop during hold or pre-start brake aborts into stop behaviour.
module dsss_top
  import dsss_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Drive outputs.
  output logic [15:0] freq_out,
  output logic output_on,
  output logic dc_brake_on,
  output logic [15:0] dc_brake_current
);
  logic [31:0] unused_hsize;
  assign unused_hsize = {29'h0, hsize};

  // Bus address phase capture.
  logic wr_pend_q, wr_pend_d;
  logic rd_pend_q, rd_pend_d;
  logic [7:0] addr_q, addr_d;
  logic [31:0] hrdata_d;
  logic [15:0] cmd_q, cmd_d;
  logic rf_we;
  logic [15:0] rf_rdata;
  logic [NREG*16-1:0] words;
  logic [15:0] status_w;

  function automatic logic [15:0] word(input logic [NREG*16-1:0] w,
                                       input logic [7:0] ofs);
    return w[(ofs >> 2)*16 +: 16];
  endfunction : word

  // Clamp a setting to its documented range.
  function automatic logic [15:0] clamp(input logic [15:0] v,
                                        input logic [15:0] lim);
    return (v > lim) ? lim : v;
  endfunction : clamp

  always_comb begin
    wr_pend_d = 1'b0;
    rd_pend_d = 1'b0;
    addr_d = addr_q;
    cmd_d = cmd_q;
    hrdata_d = hrdata;
    if (hsel && hready && htrans[1]) begin
      wr_pend_d = hwrite;
      rd_pend_d = !hwrite;
      addr_d = haddr[7:0];
    end
    if (wr_pend_q && addr_q == OFS_CMD) begin
      cmd_d = hwdata[15:0];
    end else begin
      cmd_d[CMD_TRACK_DONE_BIT] = 1'b0;
    end
    if (rd_pend_q) begin
      if (addr_q == OFS_CMD) begin
        hrdata_d = {16'h0000, cmd_q};
      end else if (addr_q == OFS_STATUS) begin
        hrdata_d = {16'h0000, status_w};
      end else if (addr_q == OFS_FREQ_OUT) begin
        hrdata_d = {16'h0000, freq_out};
      end else if (addr_q < OFS_STATUS && addr_q[1:0] == 2'h0) begin
        hrdata_d = {16'h0000, rf_rdata};
      end else begin
        hrdata_d = 32'h00000000;
      end
    end
  end

  // Writes land one cycle late so hwdata is valid in the data phase.
  assign rf_we = wr_pend_q && ((addr_q != OFS_CMD && addr_q < OFS_STATUS) ||
                               addr_q == OFS_FREQ_OUT);

  dsss_regfile u_regfile (
    .clk(clk),
    .rst_b(rst_b),
    .we(rf_we),
    .waddr(addr_q[5:2]),
    .wdata(hwdata[15:0]),
    .raddr(addr_d[5:2]),
    .rdata(rf_rdata),
    .words(words)
  );

  // Sequencer state.
  dsss_state_e state_q, state_d;
  logic [19:0] pre_q, pre_d;
  logic pre_tick;
  logic [15:0] tick_cnt_q, tick_cnt_d;
  logic [15:0] f_q, f_d;
  logic [15:0] step_q, step_d;
  logic [15:0] sect_q, sect_d;
  logic [15:0] lat_mode_q, lat_mode_d;
  logic [15:0] lat_cur_q, lat_cur_d;
  logic on_d, brk_d;

  logic run_cmd, track_done;
  logic [15:0] target, s_acc, s_dec;
  assign run_cmd = cmd_q[CMD_RUN_BIT];
  assign track_done = cmd_q[CMD_TRACK_DONE_BIT];
  // The target sits in word 0, left free because the command is a flop.
  assign target = word(words, OFS_CMD);
  assign s_acc = word(words, OFS_S_ACC);
  assign s_dec = word(words, OFS_S_DEC);
  assign pre_tick = (pre_q == 20'(TICK_CYC - 1));
  assign status_w = {6'h0, state_q};

  // Linear step per 10 ms tick: full range over ramp time in 0.1 s.
  function automatic logic [15:0] lin_step(input logic [15:0] t);
    logic [15:0] t1;
    t1 = (t == 16'h0000) ? 16'h0001 : t;
    return 16'(RST_MAX_FREQ / (t1 * 16'h000A)) + 16'h0001;
  endfunction : lin_step

  // S curve: the step grows in the start section and shrinks in the end one.
  function automatic logic [15:0] s_step(input logic [15:0] lin,
                                         input logic [15:0] el,
                                         input logic [7:0] sect,
                                         input logic [15:0] rem,
                                         input logic [7:0] esect);
    logic [15:0] s10, e10, st;
    s10 = {8'h00, sect} * 16'h000A;
    e10 = {8'h00, esect} * 16'h000A;
    st = lin;
    if (el < s10) begin
      st = 16'(({16'h0, lin} * {16'h0, el + 16'h0001}) / {16'h0, s10});
    end
    if (rem < 16'(({16'h0, lin} * {16'h0, e10}) >> 1)) begin
      st = 16'((st + 16'h0001) >> 1);
    end
    return (st == 16'h0000) ? 16'h0001 : st;
  endfunction : s_step

  function automatic logic [15:0] ramp_step(input logic shape,
                                            input logic [15:0] lin,
                                            input logic [15:0] el,
                                            input logic [7:0] sect,
                                            input logic [15:0] rem,
                                            input logic [7:0] esect);
    if (shape) begin
      return s_step(lin, el, sect, rem, esect); // R10 R11
    end
    return lin; // R9
  endfunction : ramp_step

  always_comb begin
    logic [15:0] st;
    logic [15:0] stop_spd, thr, fs;
    st = 16'h0000;
    state_d = state_q;
    pre_d = pre_tick ? 20'h00000 : pre_q + 20'h00001;
    tick_cnt_d = tick_cnt_q;
    f_d = f_q;
    step_d = step_q;
    sect_d = sect_q;
    lat_mode_d = lat_mode_q;
    lat_cur_d = lat_cur_q;
    on_d = 1'b0;
    brk_d = 1'b0;
    stop_spd = word(words, OFS_STOP_SPD);
    thr = word(words, OFS_POST_THR);
    fs = clamp(word(words, OFS_START_FREQ), MAX_START_FREQ); // R2 R5
    if (pre_tick && tick_cnt_q != 16'h0000) begin
      tick_cnt_d = tick_cnt_q - 16'h0001; // R18
    end
    case (state_q)
      ST_IDLE: begin
        f_d = 16'h0000;
        if (run_cmd) begin
          lat_mode_d = word(words, OFS_MODE); // R18
          if (target < fs) begin
            state_d = ST_STANDBY; // R4
          end else if (word(words, OFS_MODE)[MODE_START_LSB +: 2] ==
                       START_BRAKE &&
                       word(words, OFS_PRE_TIME) != 16'h0000) begin
            state_d = ST_PRE_BRAKE; // R1 R6
            tick_cnt_d = clamp(word(words, OFS_PRE_TIME), MAX_PRE_TIME);
            lat_cur_d = clamp(word(words, OFS_PRE_CUR), MAX_CURRENT); // R8
          end else if (word(words, OFS_MODE)[MODE_START_LSB +: 2] ==
                       START_TRACK) begin
            state_d = ST_TRACK; // R1
          end else begin
            state_d = ST_HOLD; // R1 R7
            f_d = fs; // R2
            tick_cnt_d = clamp(word(words, OFS_HOLD_TIME), MAX_HOLD) *
                         16'h000A; // R3
          end
        end
      end
      ST_STANDBY: begin
        if (!run_cmd) begin
          state_d = ST_IDLE;
        end else if (target >= fs) begin
          state_d = ST_IDLE;
        end
      end
      ST_PRE_BRAKE: begin
        brk_d = 1'b1; // R6
        if (!run_cmd) begin
          state_d = ST_IDLE; // R19
        end else if (tick_cnt_q == 16'h0000) begin
          state_d = ST_HOLD; // R6
          f_d = fs;
          tick_cnt_d = 16'h0000;
        end
      end
      ST_TRACK: begin
        if (!run_cmd) begin
          state_d = ST_IDLE;
        end else if (track_done) begin
          state_d = ST_HOLD;
          f_d = fs;
          tick_cnt_d = 16'h0000;
        end
      end
      ST_HOLD: begin
        on_d = 1'b1;
        sect_d = 16'h0000;
        if (!run_cmd) begin
          state_d = lat_mode_q[MODE_STOP_BIT] ? ST_COAST : ST_DECEL; // R19
          sect_d = 16'h0000;
        end else if (tick_cnt_q == 16'h0000) begin
          state_d = ST_RUN; // R3
        end
      end
      ST_RUN: begin
        on_d = 1'b1;
        if (!run_cmd) begin
          lat_mode_d = word(words, OFS_MODE); // R18
          state_d = word(words, OFS_MODE)[MODE_STOP_BIT] ? ST_COAST :
                    ST_DECEL; // R12 R13
          sect_d = 16'h0000;
        end else if (pre_tick && f_q < target) begin
          st = ramp_step(lat_mode_q[MODE_RAMP_BIT],
                         lin_step(word(words, OFS_ACC_TIME)), sect_q,
                         s_acc[7:0], target - f_q, s_acc[15:8]);
          f_d = (target - f_q < st) ? target : f_q + st;
          sect_d = sect_q + 16'h0001;
        end else if (pre_tick && f_q > target) begin
          st = ramp_step(lat_mode_q[MODE_RAMP_BIT],
                         lin_step(word(words, OFS_DEC_TIME)), sect_q,
                         s_dec[7:0], f_q - target, s_dec[15:8]);
          f_d = (f_q - target < st) ? target : f_q - st;
          sect_d = sect_q + 16'h0001;
        end
      end
      ST_DECEL: begin
        on_d = 1'b1;
        if (pre_tick) begin
          st = ramp_step(lat_mode_q[MODE_RAMP_BIT],
                         lin_step(word(words, OFS_DEC_TIME)), sect_q,
                         s_dec[7:0], f_q, s_dec[15:8]);
          f_d = (f_q < st) ? 16'h0000 : f_q - st; // R12
          sect_d = sect_q + 16'h0001;
        end
        if (f_q <= thr && word(words, OFS_POST_TIME) != 16'h0000) begin
          state_d = ST_DEMAG; // R14
          on_d = 1'b0;
          tick_cnt_d = clamp(word(words, OFS_DEMAG), MAX_DEMAG); // R15 R17
          lat_cur_d = clamp(word(words, OFS_POST_CUR), MAX_CURRENT); // R17
          f_d = 16'h0000;
        end else if (f_q <= stop_spd) begin
          state_d = ST_IDLE; // R12
          on_d = 1'b0;
          f_d = 16'h0000;
        end
      end
      ST_DEMAG: begin
        if (tick_cnt_q == 16'h0000) begin
          state_d = ST_POST_BRAKE; // R15
          tick_cnt_d = clamp(word(words, OFS_POST_TIME), MAX_POST_TIME) *
                       16'h000A; // R16 R17
        end
      end
      ST_POST_BRAKE: begin
        brk_d = 1'b1; // R16
        if (tick_cnt_q == 16'h0000) begin
          state_d = ST_IDLE;
          brk_d = 1'b0;
        end
      end
      ST_COAST: begin
        f_d = 16'h0000; // R13
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    if (state_d == ST_PRE_BRAKE && state_q == ST_PRE_BRAKE &&
        tick_cnt_q == 16'h0000) begin
      brk_d = 1'b0;
    end
    if (state_d == ST_IDLE || state_d == ST_COAST) begin
      on_d = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q <= 8'h00;
      cmd_q <= 16'h0000;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      state_q <= ST_IDLE;
      pre_q <= 20'h00000;
      tick_cnt_q <= 16'h0000;
      f_q <= 16'h0000;
      step_q <= 16'h0000;
      sect_q <= 16'h0000;
      lat_mode_q <= 16'h0000;
      lat_cur_q <= 16'h0000;
      freq_out <= 16'h0000;
      output_on <= 1'b0;
      dc_brake_on <= 1'b0;
      dc_brake_current <= 16'h0000;
    end else begin
      wr_pend_q <= wr_pend_d;
      rd_pend_q <= rd_pend_d;
      addr_q <= addr_d;
      cmd_q <= cmd_d;
      hrdata <= hrdata_d;
      hreadyout <= !rd_pend_d;
      hresp <= 1'b0;
      state_q <= state_d;
      pre_q <= pre_d;
      tick_cnt_q <= tick_cnt_d;
      f_q <= f_d;
      step_q <= step_d;
      sect_q <= sect_d;
      lat_mode_q <= lat_mode_d;
      lat_cur_q <= lat_cur_d;
      freq_out <= on_d ? f_d : 16'h0000;
      output_on <= on_d;
      dc_brake_on <= brk_d;
      dc_brake_current <= brk_d ? lat_cur_d : 16'h0000;
    end
  end
endmodule : dsss_top

// File: hw/dsss_pkg.sv
// Constants, register map and types of the drive start/stop sequencer.
package dsss_pkg;
  // Clock and time base.
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned TICK_MS = 10;
  localparam int unsigned TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  // Register byte offsets.
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_MODE = 8'h04;
  localparam logic [7:0] OFS_START_FREQ = 8'h08;
  localparam logic [7:0] OFS_HOLD_TIME = 8'h0C;
  localparam logic [7:0] OFS_PRE_CUR = 8'h10;
  localparam logic [7:0] OFS_PRE_TIME = 8'h14;
  localparam logic [7:0] OFS_ACC_TIME = 8'h18;
  localparam logic [7:0] OFS_DEC_TIME = 8'h1C;
  localparam logic [7:0] OFS_S_ACC = 8'h20;
  localparam logic [7:0] OFS_S_DEC = 8'h24;
  localparam logic [7:0] OFS_POST_THR = 8'h28;
  localparam logic [7:0] OFS_DEMAG = 8'h2C;
  localparam logic [7:0] OFS_POST_CUR = 8'h30;
  localparam logic [7:0] OFS_POST_TIME = 8'h34;
  localparam logic [7:0] OFS_STOP_SPD = 8'h38;
  localparam logic [7:0] OFS_STATUS = 8'h3C;
  localparam logic [7:0] OFS_FREQ_OUT = 8'h40;
  localparam int unsigned NREG = 15;
  // Field positions inside the mode register.
  localparam int unsigned MODE_START_LSB = 0;
  localparam int unsigned MODE_RAMP_BIT = 4;
  localparam int unsigned MODE_STOP_BIT = 8;
  // Command bits.
  localparam int unsigned CMD_RUN_BIT = 0;
  localparam int unsigned CMD_TRACK_DONE_BIT = 1;
  // Limits and reset values (0.01 Hz, 0.1 s, 0.01 s, 0.1 % units).
  localparam logic [15:0] MAX_START_FREQ = 16'h1388;
  localparam logic [15:0] MAX_HOLD = 16'h01F4;
  localparam logic [15:0] MAX_PRE_TIME = 16'h1388;
  localparam logic [15:0] MAX_CURRENT = 16'h03E8;
  localparam logic [15:0] MAX_S_SECT = 16'h01F4;
  localparam logic [15:0] MAX_DEMAG = 16'h0BB8;
  localparam logic [15:0] MAX_POST_TIME = 16'h01F4;
  localparam logic [15:0] RST_S_SECT = 16'h0001;
  localparam logic [15:0] RST_ZERO = 16'h0000;
  localparam logic [15:0] RST_RAMP_TIME = 16'h0064;
  localparam logic [15:0] RST_MAX_FREQ = 16'h1388;
  localparam logic [15:0] RST_STOP_SPD = 16'h0032;
  // Start modes.
  localparam logic [1:0] START_DIRECT = 2'h0;
  localparam logic [1:0] START_BRAKE = 2'h1;
  localparam logic [1:0] START_TRACK = 2'h2;

  typedef enum logic [9:0] {
    ST_IDLE = 10'b0000000001,
    ST_STANDBY = 10'b0000000010,
    ST_PRE_BRAKE = 10'b0000000100,
    ST_TRACK = 10'b0000001000,
    ST_HOLD = 10'b0000010000,
    ST_RUN = 10'b0000100000,
    ST_DECEL = 10'b0001000000,
    ST_DEMAG = 10'b0010000000,
    ST_POST_BRAKE = 10'b0100000000,
    ST_COAST = 10'b1000000000
  } dsss_state_e;
endpackage : dsss_pkg

// File: hw/dsss_regfile.sv
// Small settings memory with registered read data.
module dsss_regfile
  import dsss_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Write port.
  input wire logic we,
  input wire logic [3:0] waddr,
  input wire logic [15:0] wdata,
  // Read port.
  input wire logic [3:0] raddr,
  output logic [15:0] rdata,
  // All words in parallel for the sequencer.
  output logic [NREG*16-1:0] words
);
  logic [15:0] mem_q [NREG];
  logic [15:0] mem_d [NREG];
  logic [15:0] rdata_d;

  function automatic logic [15:0] rst_val(input int unsigned i);
    if (i == 32'(OFS_ACC_TIME >> 2) || i == 32'(OFS_DEC_TIME >> 2)) begin
      return RST_RAMP_TIME;
    end else if (i == 32'(OFS_S_ACC >> 2) || i == 32'(OFS_S_DEC >> 2)) begin
      return {RST_S_SECT[7:0], RST_S_SECT[7:0]};
    end else if (i == 32'(OFS_POST_THR >> 2)) begin
      return RST_ZERO;
    end else if (i == 32'(OFS_STOP_SPD >> 2)) begin
      return RST_STOP_SPD;
    end
    return RST_ZERO;
  endfunction : rst_val

  always_comb begin
    for (int i = 0; i < NREG; i++) begin
      mem_d[i] = mem_q[i];
    end
    if (we && waddr < 4'(NREG)) begin
      mem_d[waddr] = wdata;
    end
    rdata_d = (raddr < 4'(NREG)) ? mem_d[raddr] : 16'h0000;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < NREG; i++) begin
        mem_q[i] <= rst_val(i);
      end
      rdata <= 16'h0000;
    end else begin
      for (int i = 0; i < NREG; i++) begin
        mem_q[i] <= mem_d[i];
      end
      rdata <= rdata_d;
    end
  end

  always_comb begin
    for (int i = 0; i < NREG; i++) begin
      words[i*16 +: 16] = mem_q[i];
    end
  end
endmodule : dsss_regfile

// File: verification/dsss_seq_monitor.sv
// Concurrent checks on the ports of the sequencer top.
module dsss_seq_monitor
  import dsss_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // Drive outputs.
  input wire logic [15:0] freq_out,
  input wire logic output_on,
  input wire logic dc_brake_on,
  input wire logic [15:0] dc_brake_current
);
  timeunit 1ns;
  timeprecision 1ps;
  logic rd_take;
  logic wr_take;
  logic rd_q;
  logic rd_qq;
  assign rd_take = hsel && hready && htrans[1] && !hwrite;
  assign wr_take = hsel && hready && htrans[1] && hwrite;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_q <= 1'b0;
      rd_qq <= 1'b0;
    end else begin
      rd_q <= rd_take;
      rd_qq <= rd_q;
    end
  end
  default clocking mon_cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  AST_HRESP_OKAY: assert property (hresp == 1'b0)
    else $error("Slave response is not OKAY.");
  AST_RD_WAIT: assert property (rd_take |=> !hreadyout ##1 hreadyout)
    else $error("Read data phase did not take one wait state.");
  AST_WR_NOWAIT: assert property (wr_take |=> hreadyout)
    else $error("Write data phase was stretched.");
  AST_IDLE_READY: assert property (!rd_q |-> hreadyout)
    else $error("Wait state without a pending read.");
  AST_RDATA_HOLD: assert property (!rd_q && !rd_qq |-> $stable(hrdata))
    else $error("Read data changed without a read.");
  AST_FREQ_OFF: assert property (!output_on |-> freq_out == 16'h0000)
    else $error("Frequency shown while output is off.");
  AST_BRAKE_CUR: assert property (
    !dc_brake_on |-> dc_brake_current == 16'h0000)
    else $error("Brake current shown without brake.");
  AST_CUR_MAX: assert property (dc_brake_current <= MAX_CURRENT)
    else $error("Brake current above full scale.");
  AST_BRAKE_FREQ: assert property (dc_brake_on |-> freq_out == 16'h0000)
    else $error("Rotating frequency during DC brake.");
  AST_RAMP_STEP: assert property (
    output_on && $past(output_on) && $changed(freq_out) |=> $stable(freq_out))
    else $error("Frequency moved on two cycles in a row.");
endmodule : dsss_seq_monitor

bind dsss_top dsss_seq_monitor mon_u (.clk(clk), .rst_b(rst_b), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .freq_out(freq_out),
  .output_on(output_on), .dc_brake_on(dc_brake_on),
  .dc_brake_current(dc_brake_current));

// File: verification/dsss_load_model.sv
// Behavioural inverter stage and motor shaft driven by the sequencer.
module dsss_load_model
  import dsss_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Drive outputs of the sequencer.
  input wire logic [15:0] freq_out,
  input wire logic output_on,
  input wire logic dc_brake_on,
  input wire logic [15:0] dc_brake_current,
  // Shaft state.
  output logic [15:0] motor_freq,
  output logic brake_active
);
  timeunit 1ns;
  timeprecision 1ps;
  // An unpowered shaft slows by inertia, so speed decays slowly; an active DC brake stops it at once.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      motor_freq <= 16'h0000;
      brake_active <= 1'b0;
    end else begin
      brake_active <= dc_brake_on && (dc_brake_current != 16'h0000);
      if (output_on) begin
        motor_freq <= freq_out;
      end else if (brake_active) begin
        motor_freq <= 16'h0000;
      end else if (motor_freq != 16'h0000) begin
        motor_freq <= motor_freq - 16'h0001;
      end
    end
  end
endmodule : dsss_load_model

// File: verification/dsss_top_tb.sv
// Self-checking testbench of the drive start/stop sequencer.
module dsss_top_tb
  import dsss_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_b, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, d;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [15:0] freq_out, dc_brake_current, motor_freq;
  logic output_on, dc_brake_on, brake_active;
  int err_count, num_checks, i;
  logic [7:0] rst_ofs [16] = '{OFS_MODE, OFS_START_FREQ, OFS_HOLD_TIME,
    OFS_PRE_CUR, OFS_PRE_TIME, OFS_ACC_TIME, OFS_DEC_TIME, OFS_S_ACC,
    OFS_S_DEC, OFS_POST_THR, OFS_DEMAG, OFS_POST_CUR, OFS_POST_TIME,
    OFS_STOP_SPD, OFS_STATUS, OFS_FREQ_OUT};
  logic [15:0] rst_val [16] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0064, 16'h0064, 16'h0101, 16'h0101, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0032, 16'h0001, 16'h0000};
  // Settings past their range are kept as written and limited where used.
  logic [7:0] clp_ofs [5] = '{OFS_START_FREQ, OFS_HOLD_TIME, OFS_PRE_CUR,
    OFS_DEMAG, OFS_POST_TIME};
  logic [15:0] clp_val [5] = '{MAX_START_FREQ, MAX_HOLD, MAX_CURRENT,
    MAX_DEMAG, MAX_POST_TIME};

  dsss_top dut_u (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .freq_out(freq_out), .output_on(output_on),
    .dc_brake_on(dc_brake_on), .dc_brake_current(dc_brake_current));
  dsss_load_model load_u (.clk(clk), .rst_b(rst_b), .freq_out(freq_out),
    .output_on(output_on), .dc_brake_on(dc_brake_on),
    .dc_brake_current(dc_brake_current), .motor_freq(motor_freq),
    .brake_active(brake_active));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic fail(input string msg);
    err_count++;
    $display("Error at %0t: %s", $time, msg);
  endtask : fail
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) fail($sformatf("register %h, expected %h", got, exp));
  endtask : chk_reg
  task automatic chk_out(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) fail($sformatf("output %h, expected %h", got, exp));
  endtask : chk_out
  task automatic chk_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) fail($sformatf("flag %b, expected %b", got, exp));
  endtask : chk_bit
  // The master holds each phase until hready is seen high at an edge.
  task automatic wait_rdy();
    int n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 100);
    if (n >= 100) fail("bus hang");
  endtask : wait_rdy
  task automatic addr_ph(input logic [7:0] ofs, input logic wr);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h000000, ofs};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
  endtask : addr_ph
  task automatic bus_wr(input logic [7:0] ofs, input logic [31:0] v);
    addr_ph(ofs, 1'b1);
    hwdata <= v;
    wait_rdy();
  endtask : bus_wr
  task automatic bus_rd(input logic [7:0] ofs, output logic [31:0] v);
    addr_ph(ofs, 1'b0);
    wait_rdy();
    v = hrdata;
  endtask : bus_rd
  task automatic wait_state(input dsss_state_e st);
    logic [31:0] v;
    for (int k = 0; k < 40; k++) begin
      bus_rd(OFS_STATUS, v);
      if (v === {22'h0, st}) break;
    end
    chk_reg(v, {22'h0, st});
  endtask : wait_state
  task automatic do_reset();
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
  endtask : do_reset
  task automatic summarize();
    if (err_count == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : summarize

  initial begin
    repeat (20000) @(posedge clk);
    fail("watchdog expired");
    summarize();
  end

  initial begin
    rst_b = 1'b0;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    err_count = 0;
    num_checks = 0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    for (i = 0; i < 16; i++) begin
      bus_rd(rst_ofs[i], d);
      chk_reg(d, {16'h0000, rst_val[i]});
    end
    bus_wr(8'h44, 32'h0000FFFF);
    bus_rd(8'h44, d);
    chk_reg(d, 32'h00000000);
    for (i = 0; i < 5; i++) begin
      bus_wr(clp_ofs[i], {16'h0000, clp_val[i] + 16'h0001});
      bus_rd(clp_ofs[i], d);
      chk_reg(d, {16'h0000, clp_val[i] + 16'h0001});
    end
    // Target below the start frequency leaves the drive in standby.
    bus_wr(OFS_START_FREQ, 32'h00000800);
    bus_wr(OFS_FREQ_OUT, 32'h00000400);
    bus_wr(OFS_CMD, 32'h00000001);
    wait_state(ST_STANDBY);
    chk_bit(output_on, 1'b0);
    bus_wr(OFS_CMD, 32'h00000000);
    wait_state(ST_IDLE);
    // Direct start with a long hold, then a coast stop in mid-hold.
    bus_wr(OFS_MODE, 32'h00000100);
    bus_wr(OFS_START_FREQ, 32'h000000C8);
    bus_wr(OFS_HOLD_TIME, 32'h000001F4);
    bus_wr(OFS_FREQ_OUT, 32'h00001000);
    bus_wr(OFS_CMD, 32'h00000001);
    wait_state(ST_HOLD);
    chk_out(freq_out, 16'h00C8);
    chk_out(motor_freq, 16'h00C8);
    bus_wr(OFS_CMD, 32'h00000000);
    repeat (2) @(posedge clk);
    chk_bit(output_on, 1'b0);
    wait_state(ST_IDLE);
    // Brake before start at full current, aborted by a stop.
    do_reset();
    bus_wr(OFS_MODE, 32'h00000001);
    bus_wr(OFS_PRE_CUR, 32'h000003E9);
    bus_wr(OFS_PRE_TIME, 32'h00001388);
    bus_wr(OFS_FREQ_OUT, 32'h00001000);
    bus_wr(OFS_CMD, 32'h00000001);
    wait_state(ST_PRE_BRAKE);
    chk_bit(dc_brake_on, 1'b1);
    chk_out(dc_brake_current, 16'h03E8);
    chk_bit(brake_active, 1'b1);
    bus_wr(OFS_CMD, 32'h00000000);
    wait_state(ST_IDLE);
    chk_bit(dc_brake_on, 1'b0);
    // A zero brake time goes straight to the start hold.
    bus_wr(OFS_PRE_TIME, 32'h00000000);
    bus_wr(OFS_HOLD_TIME, 32'h000001F4);
    bus_wr(OFS_START_FREQ, 32'h00000064);
    bus_wr(OFS_CMD, 32'h00000001);
    wait_state(ST_HOLD);
    chk_bit(dc_brake_on, 1'b0);
    // Speed tracking waits for its done strobe before the hold.
    do_reset();
    bus_wr(OFS_MODE, 32'h00000002);
    bus_wr(OFS_HOLD_TIME, 32'h000001F4);
    bus_wr(OFS_FREQ_OUT, 32'h00001000);
    bus_wr(OFS_CMD, 32'h00000001);
    wait_state(ST_TRACK);
    bus_wr(OFS_CMD, 32'h00000003);
    wait_state(ST_RUN);
    // Both ramp shapes: zero hold runs, a ramped stop keeps output on.
    for (i = 0; i < 2; i++) begin
      do_reset();
      bus_wr(OFS_MODE, {27'h0, i[0], 4'h0});
      bus_wr(OFS_START_FREQ, 32'h00000064);
      bus_wr(OFS_FREQ_OUT, 32'h00001000);
      bus_wr(OFS_CMD, 32'h00000001);
      wait_state(ST_RUN);
      bus_wr(OFS_CMD, 32'h00000000);
      wait_state(ST_DECEL);
      chk_bit(output_on, 1'b1);
    end
    summarize();
  end
endmodule : dsss_top_tb
